/* design/afsf_pkg.sv */
// Purpose: Shared constants for the auxiliary function strobe and flag block
// Assumes: One 200 MHz clock, ladder scan marked by a one-cycle enable
// Notes: Timing counts derive from printed times and the clock rate
package afsf_pkg;
    localparam int AFSF_CLK_MHZ = 200;
    localparam int AFSF_NUM_SW = 16;
    localparam int AFSF_POS_W = 32;
    localparam int AFSF_CODE_W = 32;
    localparam int AFSF_GEAR_W = 2;
    // Longest switch lag in microseconds (0.06 s); loop time subtracts
    localparam int AFSF_LAG_MAX_US = 60000;
    localparam int AFSF_LAG_MAX_CYC = AFSF_LAG_MAX_US * AFSF_CLK_MHZ;
    // Unused tool status value
    localparam logic [3:0] AFSF_TOOL_UNUSED = 4'h0;
    localparam logic AFSF_RST_STROBE = 1'b0;
    localparam logic AFSF_RST_FLAG = 1'b0;
    typedef enum logic {
        AFSF_TLM_LATHE,
        AFSF_TLM_CENTRE
    } afsf_tlm_e;
endpackage

/* design/afsf_strobe.sv */
// Purpose: One function strobe with finish handshake and code hold
// Assumes: Scan enable marks ladder scan boundaries
// Notes: Reset condition and finish both clear; lock suppresses the set
`timescale 1ns/1ps
module afsf_strobe
    import afsf_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset
    input wire logic scan_en, // Ladder scan boundary pulse
    input wire logic cmd, // Code commanded this cycle
    input wire logic [W-1:0] cmd_data, // Commanded code
    input wire logic lock, // Function lock
    input wire logic finish, // Finish one or two, combined by an OR in the top level
    input wire logic reset_cond, // Controller reset condition
    output logic strobe, // Strobe to sequence program
    output logic [W-1:0] data // Code data held with strobe
);
    logic pend;
    logic next_pend;
    logic next_strobe;
    logic [W-1:0] next_data;

    // Command is held pending until the next scan boundary, then published
    always_comb begin
        next_pend = pend;
        next_strobe = strobe;
        next_data = data;
        if (cmd && !lock) begin
            next_pend = 1'b1;
            next_data = cmd_data;
        end
        if (scan_en) begin
            if (finish) begin
                next_strobe = 1'b0;
            end else if (pend) begin
                next_strobe = 1'b1;
                next_pend = cmd && !lock;
            end
        end
        if (reset_cond) begin
            next_pend = 1'b0;
            next_strobe = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
            strobe <= AFSF_RST_STROBE;
            data <= '0;
        end else begin
            pend <= next_pend;
            strobe <= next_strobe;
            data <= next_data;
        end
    end

    a_strobe_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (scan_en && finish && !reset_cond) |=> !strobe)
        else $error("strobe survived finish");
    a_strobe_on_scan: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(strobe) |-> $past(scan_en))
        else $error("strobe rose off scan boundary");
endmodule

/* design/afsf_top.sv */
// Purpose: Controller interface strobes and flags for the sequence program
// Assumes: Inputs synchronous to ref_clk; scan_en one cycle per ladder scan
// Notes: Area positions are sampled each scan; lag far under 0.06 s
//
// Overview of operation
// - Lathe variant sets new-tool flag when selected tool status is zero.
// - Lathe variant clears new-tool flag when tool command finishes.
// - Centre variant sets new-tool flag while standby tool is unused.
// - Centre variant clears it on standby change, stays set if new unused.
// - Centre flag does not change in the scan of the standby change.
// - Tool strobe with code data on automatic or manual tool command.
// - Strobes hold until finish one or two, or reset condition.
// - Function lock suppresses the tool strobe.
// - Second-miscellaneous strobe on automatic or manual command.
// - Function lock suppresses second-miscellaneous and spindle strobes.
// - At most one second-miscellaneous code accepted per block.
// - Spindle strobe with code data on automatic or manual command.
// - Gear stage code and no-gear flag go out with spindle strobe.
// - Each of 16 switches is on while position lies inside range.
// - Range runs from smaller to larger boundary, in either order.
// - Absolute detection: switches valid after power-on past zero init.
// - Incremental detection: switches off until first zero return.
// - Switch lag stays under 0.06 s minus loop time constant.
// - Retract-possible set when tap halts in cutting zone by stop causes.
// - Retract-possible cleared on retract done or manual tap axis move.
// - Retract command honoured only while retract-possible is set.
`timescale 1ns/1ps
module afsf_top
    import afsf_pkg::*;
(
    input wire logic ref_clk, // 200 MHz clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic scan_en, // One pulse per ladder scan
    input wire logic reset_cond, // Controller reset condition
    input wire logic finish_one, // Finish one from sequence program
    input wire logic finish_two, // Finish two from sequence program
    input wire logic misc_function_lock, // Function lock
    input wire logic block_start, // New program block begins
    input wire logic tool_cmd, // Tool code commanded
    input wire logic [AFSF_CODE_W-1:0] tool_code_in, // Tool code
    input wire logic second_cmd, // Second-misc code commanded
    input wire logic [AFSF_CODE_W-1:0] second_code_in, // Second-misc code
    input wire logic spindle_cmd, // Spindle code commanded
    input wire logic [AFSF_CODE_W-1:0] spindle_code_in, // Spindle code
    input wire logic [AFSF_GEAR_W-1:0] gear_stage_in, // Gear for spindle code
    input wire logic no_gear_in, // Spindle code fits no gear
    input wire afsf_tlm_e tlm_mode, // Tool life management variant
    input wire logic [3:0] sel_tool_status, // Status of selected tool
    input wire logic [3:0] standby_status, // Status of standby tool
    input wire logic standby_change, // Standby tool replaced
    input wire logic abs_detect, // Absolute position detection
    input wire logic zero_init_done, // Zero init completed before power-on
    input wire logic zero_return_done, // First zero return completed
    input wire logic [AFSF_POS_W-1:0] sw_pos [AFSF_NUM_SW], // Axis position
    input wire logic [AFSF_POS_W-1:0] sw_bound_a [AFSF_NUM_SW], // Boundary
    input wire logic [AFSF_POS_W-1:0] sw_bound_b [AFSF_NUM_SW], // Boundary
    input wire logic tap_halt_cut, // Tap stopped in cutting zone
    input wire logic halt_estop, // Stop cause emergency stop
    input wire logic halt_reset, // Stop cause reset
    input wire logic halt_power, // Stop cause power loss
    input wire logic retract_done, // Tap retract completed
    input wire logic tap_axis_manual, // Tap axis moved manually
    input wire logic retract_command, // Retract request from program
    output logic tool_code_strobe, // Tool strobe
    output logic [AFSF_CODE_W-1:0] tool_code, // Tool code data
    output logic second_misc_strobe, // Second-misc strobe
    output logic [AFSF_CODE_W-1:0] second_code, // Second-misc data
    output logic spindle_code_strobe, // Spindle strobe
    output logic [AFSF_CODE_W-1:0] spindle_code, // Spindle data
    output logic [AFSF_GEAR_W-1:0] gear_stage_code, // Gear with strobe
    output logic no_gear_match_flag, // No gear with strobe
    output logic new_tool_flag, // New tool selected
    output logic [AFSF_NUM_SW-1:0] area_switch, // Area switches
    output logic retract_possible_flag, // Tap retract possible
    output logic retract_start // One-cycle accepted retract
);
    logic rst_s1, rst_n;
    logic finish;
    logic second_taken, next_second_taken;
    logic second_ok;
    logic [AFSF_GEAR_W-1:0] next_gear;
    logic next_nogear;
    logic new_tool, next_new_tool;
    logic change_seen, next_change_seen;
    logic sw_valid, next_sw_valid;
    logic [AFSF_NUM_SW-1:0] next_area;
    logic retract_ok, next_retract_ok;
    logic next_retract_start;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Range test tolerant of boundary order, used by every switch
    function automatic logic in_range(input logic [AFSF_POS_W-1:0] p,
                                      input logic [AFSF_POS_W-1:0] a,
                                      input logic [AFSF_POS_W-1:0] b);
        logic [AFSF_POS_W-1:0] lo;
        logic [AFSF_POS_W-1:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        in_range = (p >= lo) && (p <= hi);
    endfunction

    assign finish = finish_one || finish_two;
    // Only the first second-misc code of a block raises the strobe
    assign second_ok = second_cmd && !second_taken;

    afsf_strobe #(.W(AFSF_CODE_W)) u_tool (
        .clk(ref_clk), .rst_n(rst_n), .scan_en(scan_en),
        .cmd(tool_cmd), .cmd_data(tool_code_in),
        .lock(misc_function_lock), .finish(finish),
        .reset_cond(reset_cond),
        .strobe(tool_code_strobe), .data(tool_code));
    afsf_strobe #(.W(AFSF_CODE_W)) u_second (
        .clk(ref_clk), .rst_n(rst_n), .scan_en(scan_en),
        .cmd(second_ok), .cmd_data(second_code_in),
        .lock(misc_function_lock), .finish(finish),
        .reset_cond(reset_cond),
        .strobe(second_misc_strobe), .data(second_code));
    afsf_strobe #(.W(AFSF_CODE_W)) u_spindle (
        .clk(ref_clk), .rst_n(rst_n), .scan_en(scan_en),
        .cmd(spindle_cmd), .cmd_data(spindle_code_in),
        .lock(misc_function_lock), .finish(finish),
        .reset_cond(reset_cond),
        .strobe(spindle_code_strobe), .data(spindle_code));

    // Block tracking, gear capture and new-tool flag
    always_comb begin
        next_second_taken = second_taken;
        if (block_start || reset_cond) begin
            next_second_taken = 1'b0;
        end else if (second_cmd && !misc_function_lock) begin
            next_second_taken = 1'b1;
        end
        next_gear = gear_stage_code;
        next_nogear = no_gear_match_flag;
        if (spindle_cmd && !misc_function_lock) begin
            next_gear = gear_stage_in;
            next_nogear = no_gear_in;
        end
        next_new_tool = new_tool;
        next_change_seen = change_seen || standby_change;
        if (tlm_mode == AFSF_TLM_LATHE) begin
            next_change_seen = 1'b0;
            // Locked commands select nothing, so they leave the flag alone
            if (tool_cmd && !misc_function_lock &&
                sel_tool_status == AFSF_TOOL_UNUSED) begin
                next_new_tool = 1'b1;
            end else if (scan_en && finish && tool_code_strobe) begin
                // Only the tool command's own finish ends it
                next_new_tool = 1'b0;
            end
        end else if (scan_en) begin
            // Change in this scan is only acted on in the next one
            next_change_seen = standby_change;
            if (change_seen || new_tool ==
                (standby_status != AFSF_TOOL_UNUSED)) begin
                next_new_tool = (standby_status == AFSF_TOOL_UNUSED);
            end
        end
        if (reset_cond && tlm_mode == AFSF_TLM_LATHE) begin
            next_new_tool = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            second_taken <= 1'b0;
            gear_stage_code <= '0;
            no_gear_match_flag <= AFSF_RST_FLAG;
            new_tool <= AFSF_RST_FLAG;
            change_seen <= 1'b0;
            new_tool_flag <= AFSF_RST_FLAG;
        end else begin
            second_taken <= next_second_taken;
            gear_stage_code <= next_gear;
            no_gear_match_flag <= next_nogear;
            new_tool <= next_new_tool;
            change_seen <= next_change_seen;
            if (scan_en) begin
                new_tool_flag <= new_tool;
            end
        end
    end

    // Area switch validity and per-scan evaluation
    always_comb begin
        next_sw_valid = sw_valid;
        if (abs_detect ? zero_init_done : zero_return_done) begin
            next_sw_valid = 1'b1;
        end
    end

    // One comparator per switch; sampled each scan, so lag is one scan
    for (genvar i = 0; i < AFSF_NUM_SW; i++) begin : g_sw
        always_comb begin
            next_area[i] = area_switch[i];
            if (!sw_valid) begin
                next_area[i] = 1'b0;
            end else if (scan_en) begin
                next_area[i] = in_range(sw_pos[i], sw_bound_a[i],
                                        sw_bound_b[i]);
            end
        end
    end

    // Tap retract permission and command gating
    always_comb begin
        next_retract_ok = retract_ok;
        if (tap_halt_cut &&
            (halt_estop || halt_reset || (halt_power && abs_detect))) begin
            next_retract_ok = 1'b1;
        end else if (retract_done || tap_axis_manual) begin
            next_retract_ok = 1'b0;
        end
        next_retract_start = retract_command && retract_ok &&
                             !retract_start;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_valid <= 1'b0;
            area_switch <= '0;
            retract_ok <= AFSF_RST_FLAG;
            retract_possible_flag <= AFSF_RST_FLAG;
            retract_start <= 1'b0;
        end else begin
            sw_valid <= next_sw_valid;
            area_switch <= next_area;
            retract_ok <= next_retract_ok;
            retract_start <= next_retract_start;
            if (scan_en) begin
                retract_possible_flag <= retract_ok;
            end
        end
    end

    a_retract_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        retract_start |-> $past(retract_ok))
        else $error("retract accepted while not possible");
    a_switch_invalid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sw_valid |=> area_switch == '0)
        else $error("area switch on before validity");
    a_lock_no_tool: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (misc_function_lock && tool_cmd) |=> $stable(tool_code))
        else $error("tool code taken under lock");
    a_gear_with_sf: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(spindle_code_strobe) |-> !$changed(gear_stage_code))
        else $error("gear changed with strobe");
    a_flag_scan: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(new_tool_flag) |-> $past(scan_en))
        else $error("new tool flag changed off scan");
    a_retract_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tap_halt_cut && halt_estop) |=> retract_ok)
        else $error("retract possible not set");
    a_retract_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (retract_done && !tap_halt_cut) |=> !retract_ok)
        else $error("retract possible not cleared");
    a_second_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (second_cmd && second_taken) |=> $stable(second_code))
        else $error("second code accepted twice in block");
    // Further checks on what the block itself drives
    a_gear_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (spindle_cmd && !misc_function_lock) |=>
        gear_stage_code == $past(gear_stage_in))
        else $error("gear stage not captured with spindle code");
    a_new_tool_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tlm_mode == AFSF_TLM_LATHE && tool_cmd && !misc_function_lock &&
        !reset_cond && sel_tool_status == AFSF_TOOL_UNUSED) |=> new_tool)
        else $error("new tool not flagged");
    a_new_tool_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tlm_mode == AFSF_TLM_LATHE && scan_en && finish &&
        tool_code_strobe && !tool_cmd) |=> !new_tool)
        else $error("new tool flag survived finish");
    a_centre_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tlm_mode == AFSF_TLM_CENTRE && scan_en && change_seen) |=>
        new_tool == ($past(standby_status) == AFSF_TOOL_UNUSED))
        else $error("centre new tool flag wrong after change");
    a_switch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sw_valid && !scan_en) |=> $stable(area_switch))
        else $error("area switch moved between scans");
    a_retract_scan: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(retract_possible_flag) |-> $past(scan_en))
        else $error("retract flag changed off scan");
    a_strobes_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reset_cond |=> !(tool_code_strobe || second_misc_strobe ||
        spindle_code_strobe))
        else $error("strobe survived reset condition");
    a_retract_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!retract_ok && !halt_estop && !halt_reset &&
        !(halt_power && abs_detect)) |=> !retract_ok)
        else $error("retract possible set without stop cause");
endmodule

/* tb/afsf_seq_model.sv */
// Purpose: Model of the sequence program that answers function strobes
// Assumes: The program runs once per ladder scan, marked by scan_en
// Notes: Finish comes after a set number of scans, so it can be slow
`timescale 1ns/1ps
module afsf_seq_model (
    input wire logic clk, // System clock
    input wire logic scan_en, // Ladder scan pulse
    input wire logic strobe_any, // Any function strobe up
    input wire logic enable, // Answer strobes at all
    input wire logic use_two, // Answer with finish two
    input wire logic [3:0] wait_scans, // Scans before finish
    output logic finish_one, // Finish one to the block
    output logic finish_two // Finish two to the block
);
    logic [3:0] cnt = 4'h0;
    logic fin = 1'b0;

    // Finish stays up until the strobe is seen down at a later scan;
    // runs on the falling edge so the block sees settled inputs
    always @(negedge clk) begin
        if (scan_en === 1'b1) begin
            if (strobe_any !== 1'b1) begin
                cnt <= 4'h0;
                fin <= 1'b0;
            end else if (enable && (cnt + 4'h1 >= wait_scans)) begin
                fin <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end

    // Only one of the two finish lines answers at a time
    assign finish_one = fin & ~use_two;
    assign finish_two = fin & use_two;
endmodule

/* tb/afsf_top_tb.sv */
// Purpose: Self-checking bench for the function strobe and flag block
// Assumes: Scan pulse every fourth cycle, inputs driven at falling edge
// Notes: Waits count scans where strobes and flags move at a scan; after reset condition, retract command and reset they count cycles
`timescale 1ns/1ps
module afsf_top_tb
    import afsf_pkg::*;
;
    logic ref_clk, resetn = 1'b0, scan_en = 1'b0, reset_cond = 1'b0;
    logic finish_one, finish_two, lock = 1'b0, block_start = 1'b0;
    logic tool_cmd = 1'b0, second_cmd = 1'b0, spindle_cmd = 1'b0;
    logic no_gear_in = 1'b0, standby_change = 1'b0, abs_detect = 1'b0;
    logic zero_init_done = 1'b0, zero_return_done = 1'b0;
    logic tap_halt_cut = 1'b0, halt_estop = 1'b0, halt_reset = 1'b0;
    logic halt_power = 1'b0, retract_done = 1'b0, tap_axis_manual = 1'b0;
    logic retract_command = 1'b0, fin_en = 1'b1, fin_two = 1'b0;
    logic [AFSF_CODE_W-1:0] tool_code_in = '0, second_code_in = '0;
    logic [AFSF_CODE_W-1:0] spindle_code_in = '0;
    logic [AFSF_CODE_W-1:0] tool_code, second_code, spindle_code;
    logic [AFSF_GEAR_W-1:0] gear_stage_in = '0, gear_stage_code;
    afsf_tlm_e tlm_mode = AFSF_TLM_LATHE;
    logic [3:0] sel_tool_status = 4'h0, standby_status = 4'h5;
    logic [3:0] wait_scans = 4'h3;
    logic [AFSF_POS_W-1:0] sw_pos [AFSF_NUM_SW];
    logic [AFSF_POS_W-1:0] sw_bound_a [AFSF_NUM_SW];
    logic [AFSF_POS_W-1:0] sw_bound_b [AFSF_NUM_SW];
    logic tool_code_strobe, second_misc_strobe, spindle_code_strobe;
    logic no_gear_match_flag, new_tool_flag, retract_possible_flag;
    logic retract_start, strobe_any;
    logic [AFSF_NUM_SW-1:0] area_switch;
    logic [1:0] sc = 2'h0;
    int num_errors = 0, n_compared = 0, rs_cnt = 0;

    afsf_top u_dut (
        .ref_clk, .resetn, .scan_en, .reset_cond, .finish_one, .finish_two,
        .misc_function_lock(lock), .block_start, .tool_cmd, .tool_code_in,
        .second_cmd, .second_code_in, .spindle_cmd, .spindle_code_in,
        .gear_stage_in, .no_gear_in, .tlm_mode, .sel_tool_status,
        .standby_status, .standby_change, .abs_detect, .zero_init_done,
        .zero_return_done, .sw_pos, .sw_bound_a, .sw_bound_b, .tap_halt_cut,
        .halt_estop, .halt_reset, .halt_power, .retract_done,
        .tap_axis_manual, .retract_command, .tool_code_strobe, .tool_code,
        .second_misc_strobe, .second_code, .spindle_code_strobe,
        .spindle_code, .gear_stage_code, .no_gear_match_flag, .new_tool_flag,
        .area_switch, .retract_possible_flag, .retract_start
    );

    // The sequence program answers whichever strobe is up
    assign strobe_any = tool_code_strobe | second_misc_strobe
        | spindle_code_strobe;
    afsf_seq_model u_seq (
        .clk(ref_clk), .scan_en, .strobe_any, .enable(fin_en),
        .use_two(fin_two), .wait_scans, .finish_one, .finish_two
    );

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Ladder scan pulse every fourth cycle; retract pulses are counted
    always @(negedge ref_clk) begin
        sc <= sc + 2'h1;
        scan_en <= (sc == 2'h3);
    end
    always @(posedge ref_clk) begin
        if (retract_start === 1'b1) begin
            rs_cnt <= rs_cnt + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic scans(input int n);
        repeat (n) @(posedge ref_clk iff scan_en === 1'b1);
        @(negedge ref_clk);
    endtask

    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask

    // Mask bit 0 tool, bit 1 second-misc, bit 2 spindle
    task automatic issue(input logic [2:0] m, input logic [31:0] code);
        @(negedge ref_clk);
        {spindle_cmd, second_cmd, tool_cmd} = m;
        tool_code_in = code;
        second_code_in = code;
        spindle_code_in = code;
        @(negedge ref_clk);
        {spindle_cmd, second_cmd, tool_cmd} = 3'h0;
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // A hang is cut short here and counted as a mismatch
    initial begin
        #200000;
        num_errors++;
        stop_test();
    end

    // Main sequence of scenarios
    initial begin
        for (int i = 0; i < AFSF_NUM_SW; i++) begin
            sw_bound_a[i] = (i % 2) ? 32'h000000C8 : 32'h00000064;
            sw_bound_b[i] = (i % 2) ? 32'h00000064 : 32'h000000C8;
            sw_pos[i] = (i < 8) ? 32'h00000096 : 32'h00000032;
        end
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({strobe_any, new_tool_flag, retract_possible_flag}, 0);
        issue(3'h1, 32'h00001234);
        scans(2);
        check(tool_code_strobe, 1'b1);
        check(tool_code, 32'h00001234);
        check(new_tool_flag, 1'b1);
        scans(6);
        check(tool_code_strobe, 1'b0);
        check(new_tool_flag, 1'b0);
        fin_two = 1'b1;
        gear_stage_in = 2'h2;
        no_gear_in = 1'b1;
        issue(3'h4, 32'h00000BB8);
        gear_stage_in = 2'h1;
        no_gear_in = 1'b0;
        scans(2);
        check(spindle_code_strobe, 1'b1);
        check(spindle_code, 32'h00000BB8);
        check({gear_stage_code, no_gear_match_flag}, 3'h5);
        scans(6);
        check(spindle_code_strobe, 1'b0);
        fin_two = 1'b0;
        pulse(block_start);
        issue(3'h2, 32'h0000000A);
        scans(2);
        check(second_misc_strobe, 1'b1);
        check(second_code, 32'h0000000A);
        scans(6);
        check(second_misc_strobe, 1'b0);
        issue(3'h2, 32'h0000000B);
        scans(2);
        check(second_misc_strobe, 1'b0);
        pulse(block_start);
        issue(3'h2, 32'h0000000C);
        scans(2);
        check(second_code, 32'h0000000C);
        scans(6);
        lock = 1'b1;
        pulse(block_start);
        issue(3'h7, 32'h00000055);
        scans(3);
        check(tool_code_strobe, 1'b0);
        check({second_misc_strobe, spindle_code_strobe}, 2'h0);
        lock = 1'b0;
        fin_en = 1'b0;
        sel_tool_status = 4'h3;
        issue(3'h1, 32'h00000077);
        scans(2);
        check(tool_code_strobe, 1'b1);
        check(new_tool_flag, 1'b0);
        pulse(reset_cond);
        repeat (2) @(negedge ref_clk);
        check(tool_code_strobe, 1'b0);
        fin_en = 1'b1;
        tlm_mode = AFSF_TLM_CENTRE;
        standby_status = 4'h0;
        pulse(standby_change);
        scans(3);
        check(new_tool_flag, 1'b1);
        pulse(standby_change);
        scans(3);
        check(new_tool_flag, 1'b1);
        standby_status = 4'h5;
        pulse(standby_change);
        scans(3);
        check(new_tool_flag, 1'b0);
        check(area_switch, 16'h0000);
        zero_return_done = 1'b1;
        scans(2);
        check(area_switch, 16'h00FF);
        sw_pos[0] = 32'h0000012C;
        scans(2);
        check(area_switch, 16'h00FE);
        pulse(retract_command);
        repeat (2) @(negedge ref_clk);
        check(rs_cnt, 0);
        tap_halt_cut = 1'b1;
        halt_power = 1'b1;
        scans(2);
        check(retract_possible_flag, 1'b0);
        halt_power = 1'b0;
        halt_estop = 1'b1;
        scans(2);
        check(retract_possible_flag, 1'b1);
        tap_halt_cut = 1'b0;
        halt_estop = 1'b0;
        pulse(retract_command);
        repeat (2) @(negedge ref_clk);
        check(rs_cnt, 1);
        pulse(retract_done);
        scans(2);
        check(retract_possible_flag, 1'b0);
        tap_halt_cut = 1'b1;
        halt_reset = 1'b1;
        scans(2);
        check(retract_possible_flag, 1'b1);
        tap_halt_cut = 1'b0;
        halt_reset = 1'b0;
        pulse(tap_axis_manual);
        scans(2);
        check(retract_possible_flag, 1'b0);
        // Second power-on with absolute detection after zero init
        abs_detect = 1'b1;
        zero_init_done = 1'b1;
        zero_return_done = 1'b0;
        resetn = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(area_switch, 16'h0000);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        scans(2);
        check(area_switch, 16'h00FE);
        tap_halt_cut = 1'b1;
        halt_power = 1'b1;
        scans(2);
        check(retract_possible_flag, 1'b1);
        stop_test();
    end
endmodule
